// *** logic/rch_holdoff_reval.v ***
// reference hold-off and re-validation counters with an axi4-lite slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rch_regs.vh"

// How it works
// - holdover mode: switch only at hold-off zero
// - hold-off countdown starts on active-input loss
// - one decrement per divided vcxo tick
// - hold-off reloads from setting after zero
// - hold-off count resets to 128
// - divider codes: 2^15, 2^16, 2^17; reset 10
// - each of four inputs re-validates independently
// - load on loss, decrement per valid period
// - missing edge reloads re-validation counter
// - zero transition clears that input's loss flag
// - mode code 11 is automatic with holdover
// - codes map 2/16/32/64, times four with pre-divider
module rch_holdoff_reval #(
    parameter ADDR_W = 8,
    parameter N_IN = 4,
    parameter HDIV0 = `RCH_HDIV0,
    parameter HDIV1 = `RCH_HDIV1,
    parameter HDIV2 = `RCH_HDIV2,
    parameter LOS_TIMEOUT = `RCH_LOS_TIMEOUT
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [N_IN-1:0] ref_clk_in,
    input wire [1:0] active_ref,
    output reg switch_req,
    output reg [N_IN-1:0] los_flag,
    output wire irq
);

    // hold-off state machine, one-hot
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_COUNT = 2'b10;

    // software fields
    reg [1:0] input_select_mode_q; // selection mode
    reg [1:0] holdoff_ref_divider_q; // hold-off tick ratio
    reg [1:0] revalidation_count_q; // re-validation length code
    reg revalidation_prediv_q; // x4 pre-divider on edges
    reg [7:0] holdoff_count_q; // hold-off reload value
    reg [`RCH_IRQ_W-1:0] irq_st_q; // sticky event bits
    reg [`RCH_IRQ_W-1:0] irq_mask_q; // interrupt enables

    // bus holding registers
    reg aw_hold_q;
    reg [ADDR_W-1:0] aw_addr_q;
    reg w_hold_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    // hold-off datapath
    reg [16:0] div_cnt_q; // divided vcxo tick counter
    reg [16:0] div_last; // terminal count for the chosen ratio
    wire tick;
    reg [1:0] state_q;
    reg [7:0] hold_cnt_q; // live hold-off counter

    // per-input results
    wire [N_IN-1:0] los_evt; // one-cycle loss event
    wire [N_IN-1:0] reval_evt; // one-cycle re-validation
    reg [7:0] reval_base; // periods for the chosen code

    // write decode
    wire wr_en;
    reg [ADDR_W-1:0] wr_ofs;
    reg [31:0] wr_bits; // write data gated by byte strobes
    reg wr_ok;
    integer k;

    // write performed once both halves of the write are held and no response is pending
    assign wr_en = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    // byte-lane masking and decode of the held write
    always @* begin
        wr_ofs = aw_addr_q;
        for (k = 0; k < 4; k = k + 1) begin
            wr_bits[8*k +: 8] = w_data_q[8*k +: 8] & {8{w_strb_q[k]}};
        end
        case (aw_addr_q)
            `RCH_OFS_CTRL, `RCH_OFS_HOLDOFF, `RCH_OFS_STATUS,
            `RCH_OFS_IRQ_STATUS, `RCH_OFS_IRQ_MASK: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // write channel: capture address and data in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= {ADDR_W{1'b0}};
            w_hold_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RCH_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_en) begin
                // both halves present: answer next cycle
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `RCH_RESP_OKAY : `RCH_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // software registers and sticky interrupt bits
    always @(posedge aclk) begin
        if (!aresetn) begin
            input_select_mode_q <= `RCH_MODE_RST;
            holdoff_ref_divider_q <= `RCH_DIV_RST;
            revalidation_count_q <= `RCH_REVAL_RST;
            revalidation_prediv_q <= `RCH_PREDIV_RST;
            holdoff_count_q <= `RCH_HOLDOFF_RST;
            irq_mask_q <= {`RCH_IRQ_W{1'b0}};
            irq_st_q <= {`RCH_IRQ_W{1'b0}};
        end else begin
            if (wr_en && wr_ofs == `RCH_OFS_CTRL && w_strb_q[0]) begin
                input_select_mode_q <= wr_bits[`RCH_CTRL_MODE_LSB +: 2];
                holdoff_ref_divider_q <= wr_bits[`RCH_CTRL_DIV_LSB +: 2];
                revalidation_count_q <= wr_bits[`RCH_CTRL_REVAL_LSB +: 2];
                revalidation_prediv_q <= wr_bits[`RCH_CTRL_PREDIV_BIT];
            end
            if (wr_en && wr_ofs == `RCH_OFS_HOLDOFF && w_strb_q[0]) begin
                holdoff_count_q <= wr_bits[7:0];
            end
            if (wr_en && wr_ofs == `RCH_OFS_IRQ_MASK) begin
                irq_mask_q <= (irq_mask_q & ~wr_mask_sel(w_strb_q))
                    | (wr_bits[`RCH_IRQ_W-1:0] & wr_mask_sel(w_strb_q));
            end
            // write-one-to-clear; a new event in the same cycle wins
            irq_st_q <= (irq_st_q & ~((wr_en
                && wr_ofs == `RCH_OFS_IRQ_STATUS)
                ? wr_bits[`RCH_IRQ_W-1:0] : {`RCH_IRQ_W{1'b0}}))
                | {switch_req, reval_evt, los_evt};
        end
    end

    // lanes of the interrupt-wide fields enabled by the strobes
    function [`RCH_IRQ_W-1:0] wr_mask_sel;
        input [3:0] strb;
        begin
            wr_mask_sel = {strb[1], {8{strb[0]}}};
        end
    endfunction

    assign irq = |(irq_st_q & irq_mask_q);

    // read channel: one-cycle answer from the register mux
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RCH_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RCH_RESP_OKAY;
            case (s_axi_araddr)
                `RCH_OFS_CTRL: s_axi_rdata <= {25'h0, revalidation_prediv_q,
                    revalidation_count_q, holdoff_ref_divider_q,
                    input_select_mode_q};
                `RCH_OFS_HOLDOFF: s_axi_rdata <= {24'h0, holdoff_count_q};
                `RCH_OFS_STATUS: s_axi_rdata <= {19'h0, state_q[1],
                    hold_cnt_q, {(4-N_IN){1'b0}}, los_flag};
                `RCH_OFS_IRQ_STATUS: s_axi_rdata <= {23'h0, irq_st_q};
                `RCH_OFS_IRQ_MASK: s_axi_rdata <= {23'h0, irq_mask_q};
                default: begin
                    // unmapped: zero data, slave error
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RCH_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // terminal count of the vcxo divider per ratio code
    always @* begin
        case (holdoff_ref_divider_q)
            2'b00: div_last = HDIV0[16:0] - 17'd1;
            2'b01: div_last = HDIV1[16:0] - 17'd1;
            default: div_last = HDIV2[16:0] - 17'd1;
        endcase
    end

    // free-running divider producing the hold-off tick
    assign tick = (div_cnt_q >= div_last);
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_q <= 17'h0_0000;
        end else if (tick) begin
            div_cnt_q <= 17'h0_0000;
        end else begin
            div_cnt_q <= div_cnt_q + 17'd1;
        end
    end

    // hold-off counter and fail-over request
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            hold_cnt_q <= `RCH_HOLDOFF_RST;
            switch_req <= 1'b0;
        end else begin
            switch_req <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // idle: counter sits at the loaded value
                    hold_cnt_q <= holdoff_count_q;
                    if (input_select_mode_q == `RCH_MODE_AUTO_HOLD
                        && los_evt[active_ref]) begin
                        state_q <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (input_select_mode_q != `RCH_MODE_AUTO_HOLD) begin
                        state_q <= ST_IDLE;
                    end else if (tick) begin
                        if (hold_cnt_q <= 8'h01) begin
                            // zero transition: switch and reload
                            switch_req <= 1'b1;
                            hold_cnt_q <= holdoff_count_q;
                            state_q <= ST_IDLE;
                        end else begin
                            hold_cnt_q <= hold_cnt_q - 8'h01;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // re-validation periods for the programmed code
    always @* begin
        case (revalidation_count_q)
            2'b00: reval_base = `RCH_REVAL_P0;
            2'b01: reval_base = `RCH_REVAL_P1;
            2'b10: reval_base = `RCH_REVAL_P2;
            default: reval_base = `RCH_REVAL_P3;
        endcase
    end

    // per-input edge monitor and re-validation counter
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi = gi + 1) begin : g_in
            reg ref_q; // previous sample of the input
            reg [7:0] gap_q; // aclk cycles since the last edge
            reg [7:0] rv_q; // remaining valid periods
            reg [1:0] pre_q; // pre-divider phase
            wire edge_w;
            wire miss_w;

            assign edge_w = ref_clk_in[gi] & ~ref_q;
            assign miss_w = ~edge_w && gap_q == LOS_TIMEOUT[7:0] - 8'd1;
            assign los_evt[gi] = miss_w & ~los_flag[gi];
            assign reval_evt[gi] = edge_w & los_flag[gi] & rv_q == 8'd1
                & (~revalidation_prediv_q | pre_q == 2'd3);

            // edge timing and re-validation countdown
            always @(posedge aclk) begin
                if (!aresetn) begin
                    ref_q <= 1'b0;
                    gap_q <= 8'h00;
                    rv_q <= `RCH_REVAL_P2;
                    pre_q <= 2'd0;
                    los_flag[gi] <= 1'b0;
                end else begin
                    ref_q <= ref_clk_in[gi];
                    if (edge_w) begin
                        gap_q <= 8'h00;
                    end else if (gap_q < LOS_TIMEOUT[7:0]) begin
                        gap_q <= gap_q + 8'd1;
                    end
                    if (miss_w) begin
                        // loss or a missing edge: load and restart
                        rv_q <= reval_base;
                        pre_q <= 2'd0;
                        los_flag[gi] <= 1'b1;
                    end else if (edge_w && los_flag[gi]) begin
                        if (revalidation_prediv_q && pre_q != 2'd3) begin
                            pre_q <= pre_q + 2'd1;
                        end else begin
                            pre_q <= 2'd0;
                            rv_q <= rv_q - 8'd1;
                            if (rv_q == 8'd1) begin
                                los_flag[gi] <= 1'b0;
                            end
                        end
                    end
                end
            end
        end
    endgenerate

endmodule // rch_holdoff_reval
`default_nettype wire

// *** logic/rch_regs.vh ***
// register map, field positions, reset values and timing counts
`ifndef RCH_REGS_VH
`define RCH_REGS_VH

// register byte offsets
`define RCH_OFS_CTRL 8'h00
`define RCH_OFS_HOLDOFF 8'h04
`define RCH_OFS_STATUS 8'h08
`define RCH_OFS_IRQ_STATUS 8'h0C
`define RCH_OFS_IRQ_MASK 8'h10

// control register fields
`define RCH_CTRL_MODE_LSB 0
`define RCH_CTRL_DIV_LSB 2
`define RCH_CTRL_REVAL_LSB 4
`define RCH_CTRL_PREDIV_BIT 6

// reset values
`define RCH_MODE_RST 2'h0
`define RCH_DIV_RST 2'h2
`define RCH_REVAL_RST 2'h2
`define RCH_PREDIV_RST 1'b0
`define RCH_HOLDOFF_RST 8'h80

// selection mode: automatic with holdover
`define RCH_MODE_AUTO_HOLD 2'h3

// hold-off reference divider ratios (vcxo cycles per tick)
`define RCH_HDIV0 32768
`define RCH_HDIV1 65536
`define RCH_HDIV2 131072

// re-validation periods per code, pre-divider off (x4 when on)
`define RCH_REVAL_P0 8'h02
`define RCH_REVAL_P1 8'h10
`define RCH_REVAL_P2 8'h20
`define RCH_REVAL_P3 8'h40

// missing-edge timeout in aclk cycles
`define RCH_LOS_TIMEOUT 8

// interrupt status bit positions
`define RCH_IRQ_LOS_LSB 0
`define RCH_IRQ_REVAL_LSB 4
`define RCH_IRQ_SWITCH_BIT 8
`define RCH_IRQ_W 9

// axi response codes
`define RCH_RESP_OKAY 2'h0
`define RCH_RESP_SLVERR 2'h2

`endif

// *** verification/rch_holdoff_reval_bench.sv ***
// self-checking bench for the hold-off and re-validation block
`timescale 1ns/1ps
`default_nettype none
module rch_holdoff_reval_bench;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [3:0] s;
        logic [1:0] br;
        logic [31:0] rx;
        logic [1:0] rr;
    } rch_row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hf; // byte lanes of the next write
    logic s_axi_bready = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [1:0] active_ref = 2'h0; // input the selector is locked to
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, switch_req, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] ref_clk_in, los_flag;
    logic [3:0] ref_en = 4'hf; // source enables, low = dead input
    int n_errors = 0;
    int n_tests = 0;
    int n_sw = 0; // switch pulses seen
    int sw0;
    int t;
    logic [31:0] rd;
    logic [1:0] rs;
    // ordinary register cases: write with strobes, response, read back
    rch_row_t rows [8] = '{
        {8'h00, 32'h0000_0041, 4'hf, 2'h0, 32'h0000_0041, 2'h0},
        {8'h00, 32'h0000_0036, 4'hf, 2'h0, 32'h0000_0036, 2'h0},
        {8'h00, 32'h0000_002b, 4'hf, 2'h0, 32'h0000_002b, 2'h0},
        {8'h00, 32'h0000_00ff, 4'h2, 2'h0, 32'h0000_002b, 2'h0},
        {8'h04, 32'h0000_00ff, 4'hf, 2'h0, 32'h0000_00ff, 2'h0},
        {8'h10, 32'h0000_01ff, 4'hf, 2'h0, 32'h0000_01ff, 2'h0},
        {8'h10, 32'h0000_0000, 4'h1, 2'h0, 32'h0000_0100, 2'h0},
        {8'h14, 32'h0000_ffff, 4'hf, 2'h2, 32'h0000_0000, 2'h2}};
    always #50 aclk = ~aclk;
    rch_holdoff_reval #(.HDIV0(4), .HDIV1(8), .HDIV2(16),
        .LOS_TIMEOUT(8)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .ref_clk_in(ref_clk_in), .active_ref(active_ref),
        .switch_req(switch_req), .los_flag(los_flag), .irq(irq));
    rch_ref_src src (.aclk(aclk), .en(ref_en), .ref_clk(ref_clk_in));
    // count expiry pulses
    always @(posedge aclk) if (switch_req === 1'b1) n_sw <= n_sw + 1;
    task chk(input string name, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // write: address and data offered together, each released when taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        rs = s_axi_bresp;
    endtask
    task rdr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    task report_and_stop;
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // watchdog, well beyond the expected run of under a thousand cycles
    initial begin
        #(100 * 3000);
        n_errors++;
        report_and_stop;
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdr(8'h00);
        chk("ctrl reset", rd, 32'h0000_0028);
        rdr(8'h04);
        chk("holdoff reset", rd, 32'h0000_0080);
        $display("test reset done");
        foreach (rows[i]) begin
            s_axi_wstrb <= rows[i].s;
            wr(rows[i].a, rows[i].d);
            chk("bresp", {30'h0, rs}, {30'h0, rows[i].br});
            rdr(rows[i].a);
            chk("rdata", rd, rows[i].rx);
            chk("rresp", {30'h0, rs}, {30'h0, rows[i].rr});
        end
        $display("test register table done");
        // input 1 lost, unmasked loss event, sixteen-period re-validation
        wr(8'h10, 32'h0000_0002);
        wr(8'h00, 32'h0000_0010);
        ref_en <= 4'hd;
        t = 0;
        while (los_flag[1] !== 1'b1 && t < 40) begin
            @(posedge aclk);
            t++;
        end
        chk("loss", {28'h0, los_flag}, 32'h0000_0002);
        chk("irq", {31'h0, irq}, 32'h0000_0001);
        wr(8'h0c, 32'h0000_0002);
        chk("irq clear", {31'h0, irq}, 32'h0000_0000);
        ref_en <= 4'hf;
        repeat (40) @(posedge aclk);
        ref_en <= 4'hd;
        repeat (16) @(posedge aclk);
        ref_en <= 4'hf;
        repeat (40) @(posedge aclk);
        chk("restart", {31'h0, los_flag[1]}, 32'h0000_0001);
        t = 0;
        while (los_flag[1] !== 1'b0 && t < 60) begin
            @(posedge aclk);
            t++;
        end
        chk("reval", {28'h0, los_flag}, 32'h0000_0000);
        chk("reval span", {31'h0, t > 12 && t < 40}, 32'h1);
        $display("test loss and re-validation done");
        // pre-divider on, code 00: eight edges; loss off the active input
        active_ref <= 2'h1;
        wr(8'h00, 32'h0000_0043);
        sw0 = n_sw;
        ref_en <= 4'hb;
        repeat (16) @(posedge aclk);
        chk("loss 2", {28'h0, los_flag}, 32'h0000_0004);
        ref_en <= 4'hf;
        t = 0;
        while (los_flag[2] !== 1'b0 && t < 60) begin
            @(posedge aclk);
            t++;
        end
        chk("prediv span", {31'h0, t > 24 && t < 40}, 32'h1);
        chk("not active", 32'(n_sw - sw0), 32'h0000_0000);
        active_ref <= 2'h0;
        $display("test pre-divider done");
        // manual mode: a loss on the active input must not switch
        wr(8'h04, 32'h0000_0003);
        wr(8'h00, 32'h0000_0000);
        sw0 = n_sw;
        ref_en <= 4'he;
        repeat (60) @(posedge aclk);
        chk("manual", 32'(n_sw - sw0), 32'h0000_0000);
        ref_en <= 4'hf;
        repeat (30) @(posedge aclk);
        wr(8'h00, 32'h0000_0003);
        ref_en <= 4'he;
        t = 0;
        while (los_flag[0] !== 1'b1 && t < 40) begin
            @(posedge aclk);
            t++;
        end
        t = 0;
        while (switch_req !== 1'b1 && t < 40) begin
            @(posedge aclk);
            t++;
        end
        chk("holdoff", {31'h0, t >= 7 && t <= 15}, 32'h1);
        rdr(8'h08);
        chk("reload", {23'h0, rd[12:4]}, 32'h0000_0003);
        ref_en <= 4'hf;
        $display("test hold-off done");
        report_and_stop;
    end
endmodule // rch_holdoff_reval_bench
`default_nettype wire

// *** verification/rch_holdoff_reval_chk.sv ***
// assertion checker for the hold-off and re-validation block
`timescale 1ns/1ps
`default_nettype none
module rch_holdoff_reval_chk #(
    parameter ADDR_W = 8,
    parameter LOS_TIMEOUT = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire [3:0] ref_clk_in,
    input wire switch_req,
    input wire [3:0] los_flag
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reg ref0_q; // last sample of input 0
    reg [7:0] gap_q; // cycles since the last edge of input 0
    // gap timer, saturating so it never wraps back to a small value
    always @(posedge aclk) begin
        if (!aresetn) begin
            ref0_q <= 1'b0;
            gap_q <= 8'h00;
        end else begin
            ref0_q <= ref_clk_in[0];
            if (ref_clk_in[0] && !ref0_q) begin
                gap_q <= 8'h00;
            end else if (gap_q != 8'hff) begin
                gap_q <= gap_q + 8'h01;
            end
        end
    end
    property p_sw_pulse; switch_req |=> !switch_req; endproperty
    a_sw_pulse: assert property (p_sw_pulse)
        else $error("switch request longer than one cycle");
    property p_sw_los; switch_req |-> los_flag != 4'h0; endproperty
    a_sw_los: assert property (p_sw_los)
        else $error("switch request without any loss");
    property p_los_rise; $rose(los_flag[0]) |-> gap_q >= LOS_TIMEOUT - 1;
    endproperty
    a_los_rise: assert property (p_los_rise)
        else $error("loss flagged before the edge gap ran out");
    property p_los_set; gap_q == LOS_TIMEOUT + 3 |-> los_flag[0]; endproperty
    a_los_set: assert property (p_los_set)
        else $error("missing edges not flagged as loss");
    property p_reval_clr; $fell(los_flag[0]) |-> gap_q < 8'h04; endproperty
    a_reval_clr: assert property (p_reval_clr)
        else $error("loss cleared without recent edges");
    property p_wr_resp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response late");
    property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_resp: assert property (p_rd_resp)
        else $error("read response late");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");
endmodule // rch_holdoff_reval_chk
bind rch_holdoff_reval rch_holdoff_reval_chk #(.ADDR_W(ADDR_W),
    .LOS_TIMEOUT(LOS_TIMEOUT)) u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .ref_clk_in(ref_clk_in),
    .switch_req(switch_req), .los_flag(los_flag));
`default_nettype wire

// *** verification/rch_ref_src.sv ***
// reference clock sources feeding the four inputs
`timescale 1ns/1ps
`default_nettype none
module rch_ref_src (
    input wire logic aclk,
    input wire logic [3:0] en,
    output logic [3:0] ref_clk
);
    logic [1:0] ph_q = 2'h0; // phase, four aclk cycles per period
    // a dead source sits low; period stays under half the sample rate
    always @(posedge aclk) begin
        ph_q <= ph_q + 2'h1;
        ref_clk <= en & {4{ph_q[1]}};
    end
    initial ref_clk = 4'h0;
endmodule // rch_ref_src
`default_nettype wire
